// *** logic/uotgpc_pkg.sv ***
// Register map, field positions and timing constants of the USB power and interrupt block
package uotgpc_pkg;

  // Register byte addresses (no offsets printed; chosen locally)
  localparam logic [7:0] OTG_CONTROL_ADDR = 8'h00;
  localparam logic [7:0] POWER_CONTROL_ADDR = 8'h04;
  localparam logic [7:0] INTERRUPT_FLAG_ADDR = 8'h08;
  localparam logic [7:0] ERROR_FLAG_ADDR = 8'h0c;
  localparam logic [7:0] ERROR_ENABLE_ADDR = 8'h10;
  localparam logic [7:0] TRANSFER_STATUS_ADDR = 8'h14;

  // Reset values
  localparam logic [7:0] OTG_CONTROL_RST = 8'h00;
  localparam logic [7:0] POWER_CONTROL_RST = 8'h00;
  localparam logic [7:0] FLAGS_RST = 8'h00;

  // OTG control fields
  localparam int DPLUS_PULLUP_BIT = 7;
  localparam int DMINUS_PULLUP_BIT = 6;
  localparam int DPLUS_PULLDOWN_BIT = 5;
  localparam int DMINUS_PULLDOWN_BIT = 4;
  localparam int VBUS_POWER_BIT = 3;
  localparam int SW_PULL_BIT = 2;
  localparam int VBUS_CHARGE_BIT = 1;
  localparam int VBUS_DISCHARGE_BIT = 0;

  // Power control fields
  localparam int ACTIVITY_PENDING_BIT = 7;
  localparam int SLEEP_GUARD_BIT = 4;
  localparam int MODULE_BUSY_BIT = 3;
  localparam int SUSPEND_BIT = 1;
  localparam int OPERATE_BIT = 0;
  localparam logic [7:0] POWER_WRITE_MASK = 8'h13;

  // Interrupt flag fields
  localparam int STALL_BIT = 7;
  localparam int ATTACH_BIT = 6;
  localparam int RESUME_BIT = 5;
  localparam int IDLE_BIT = 4;
  localparam int TOKEN_DONE_BIT = 3;
  localparam int FRAME_START_BIT = 2;
  localparam int ERROR_SUMMARY_BIT = 1;
  localparam int BUS_RESET_BIT = 0;
  localparam logic [7:0] FLAG_CLEAR_MASK = 8'hfd;

  // Timing
  localparam int CLK_FREQ_MHZ = 100;
  localparam int LINE_TIME_NS = 2500;
  localparam int LINE_CYCLES = (LINE_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;
  localparam int IDLE_TIME_US = 3000;
  localparam int IDLE_CYCLES_DEF = IDLE_TIME_US * CLK_FREQ_MHZ;
  localparam int BUSY_TIME_NS = 200;
  localparam int BUSY_CYCLES = (BUSY_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;
  localparam int CNT_W = 20;

  // AHB-Lite codes
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;

  // Busy sequencer states
  typedef enum logic [2:0] {
    UOTG_OFF  = 3'h1,
    UOTG_ON   = 3'h2,
    UOTG_STOP = 3'h4
  } uotg_pwr_t;

endpackage

// *** logic/uotgpc_top.sv ***
// USB OTG pull, VBUS, power and interrupt flag control behind an AHB-Lite slave
// Notes on behaviour
// - Each of the four line pulls is on exactly when its selected software or hardware pull bit is one.
// - Software pull bits drive the pulls when pull control enable is set, else hardware.
// - VBUS power output follows the VBUS power-on bit.
// - VBUS charge pull-up follows the charge enable bit.
// - VBUS discharge pull-down follows the discharge enable bit.
// - Bits 31 to 8 and unimplemented bits read zero and ignore writes.
// - Activity pending reads one for a single cycle after new bus activity is detected.
// - With the sleep guard set, sleep is blocked on activity or pending notification.
// - Busy reads one while active or still winding down after disable.
// - Suspend gates the 48 MHz USB clock and puts the transceiver in low power.
// - Operation enable zero holds outputs inactive and shuts the module down.
// - Flags are set by hardware and cleared by writing one; error summary is read-only.
// - Stall flag sets on a stall handshake received (host) or sent (device).
// - Attach flag sets on attach in host mode after 2.5 us quiet, not SE0.
// - Resume flag sets after K-state held continuously for 2.5 us.
// - Idle flag sets after the bus stays idle for 3 ms.
// - Token done flag sets when a token finishes; status register shows its endpoint.
// - Clearing the token done flag advances the transfer status queue.
// - Frame start flag sets on a received SOF or the host SOF threshold.
// - Error summary sets only from error flags whose enables are set.
// - Bit 0 sets on bus reset in device mode, on detach in host mode.
//
// Design decisions made here: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
module uotgpc_top
  import uotgpc_pkg::*;
#(
  parameter int IDLE_CYCLES = IDLE_CYCLES_DEF
) (
  // Clock and reset
  input  wire logic        CORE_CLK,
  input  wire logic        RESET_N,
  // AHB-Lite slave
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  // Line state pins
  input  wire logic        LINE_DP,
  input  wire logic        LINE_DM,
  // Packet engine events and hardware pull requests
  input  wire logic [3:0]  HW_PULL_REQ,
  input  wire logic        HOST_MODE,
  input  wire logic        HOST_OPERATION_EN,
  input  wire logic        LOW_SPEED,
  input  wire logic        STALL_EVT,
  input  wire logic        TOKEN_DONE_EVT,
  input  wire logic [7:0]  TOKEN_STATUS,
  input  wire logic        FRAME_START_EVT,
  input  wire logic        BUS_RESET_EVT,
  input  wire logic        DETACH_EVT,
  input  wire logic [7:0]  ERROR_EVT,
  input  wire logic        SLEEP_REQ,
  // Analog and power controls
  output logic             DPLUS_PULLUP_EN,
  output logic             DMINUS_PULLUP_EN,
  output logic             DPLUS_PULLDOWN_EN,
  output logic             DMINUS_PULLDOWN_EN,
  output logic             VBUS_POWER_ON,
  output logic             VBUS_CHARGE_EN,
  output logic             VBUS_DISCHARGE_EN,
  output logic             USB_CLK_GATE_EN,
  output logic             XCVR_LOW_POWER,
  output logic             MODULE_ACTIVE,
  output logic             SLEEP_BLOCK,
  output logic             ACTIVITY_PENDING
);

  typedef struct packed {
    logic             dp_s1;
    logic             dp_s2;
    logic             dm_s1;
    logic             dm_s2;
    logic             ph_valid;
    logic             ph_write;
    logic [7:0]       ph_addr;
    logic [7:0]       otg_ctl;
    logic [4:0]       pwr_ctl;
    logic [7:0]       flags;
    logic [7:0]       err_flags;
    logic [7:0]       err_en;
    logic [7:0]       tok_status;
    logic [7:0]       tok_queued;
    logic             tok_full;
    logic [CNT_W-1:0] k_cnt;
    logic [CNT_W-1:0] quiet_cnt;
    logic [CNT_W-1:0] idle_cnt;
    logic [7:0]       busy_cnt;
    logic             act_pend;
    logic             prev_active;
    uotg_pwr_t        pwr_state;
    logic [31:0]      rdata;
    logic [7:0]       pulls;
    logic [2:0]       vbus;
  } uotgpc_state_t;

  uotgpc_state_t st_ff;
  uotgpc_state_t nxt_st;

  function automatic logic [CNT_W-1:0] count_up(input logic [CNT_W-1:0] c, input logic run);
    count_up = run ? ((c == {CNT_W{1'b1}}) ? c : c + 1'b1) : '0;
  endfunction

  logic       enabled;
  logic       k_state;
  logic       se0;
  logic       j_state;
  logic       bus_active;
  logic [7:0] hw_set;
  logic [7:0] wr_data;
  logic       wr_flags;
  logic [7:0] clr_mask;
  logic       busy;
  logic [3:0] pull_sel;

  always_comb begin
    enabled = st_ff.pwr_ctl[OPERATE_BIT];
    se0 = !st_ff.dp_s2 && !st_ff.dm_s2;
    // Full speed J is D+ high; low speed swaps the lines
    j_state = LOW_SPEED ? (st_ff.dm_s2 && !st_ff.dp_s2) : (st_ff.dp_s2 && !st_ff.dm_s2);
    k_state = !se0 && !j_state && (st_ff.dp_s2 ^ st_ff.dm_s2);
    bus_active = !j_state;
    // Busy as soon as operate is set, so a read right after enable already sees it
    busy = (st_ff.pwr_state != UOTG_OFF) || enabled;
    wr_data = HWDATA[7:0];
    wr_flags = st_ff.ph_valid && st_ff.ph_write && (st_ff.ph_addr == INTERRUPT_FLAG_ADDR);
    clr_mask = wr_flags ? (wr_data & FLAG_CLEAR_MASK) : 8'h00;
    hw_set = 8'h00;
    if (enabled) begin
      hw_set[STALL_BIT] = STALL_EVT;
      hw_set[ATTACH_BIT] = HOST_OPERATION_EN && !se0 &&
                           (st_ff.quiet_cnt == CNT_W'(LINE_CYCLES - 1)) && j_state;
      hw_set[RESUME_BIT] = (st_ff.k_cnt == CNT_W'(LINE_CYCLES - 1)) && k_state;
      hw_set[IDLE_BIT] = (st_ff.idle_cnt == CNT_W'(IDLE_CYCLES - 1)) && j_state;
      hw_set[TOKEN_DONE_BIT] = TOKEN_DONE_EVT;
      hw_set[FRAME_START_BIT] = FRAME_START_EVT;
      hw_set[BUS_RESET_BIT] = HOST_MODE ? DETACH_EVT : BUS_RESET_EVT;
    end
    pull_sel = st_ff.otg_ctl[SW_PULL_BIT] ? st_ff.otg_ctl[7:4] : HW_PULL_REQ;
  end

  always_comb begin
    nxt_st = st_ff;
    nxt_st.dp_s1 = LINE_DP;
    nxt_st.dp_s2 = st_ff.dp_s1;
    nxt_st.dm_s1 = LINE_DM;
    nxt_st.dm_s2 = st_ff.dm_s1;
    // Address phase capture
    nxt_st.ph_valid = 1'b0;
    if (HSEL && HREADY && (HTRANS == HTRANS_NONSEQ || HTRANS == HTRANS_SEQ)) begin
      nxt_st.ph_valid = 1'b1;
      nxt_st.ph_write = HWRITE;
      nxt_st.ph_addr = HADDR[7:0];
    end
    // Read data, only low byte is implemented
    // Read data holds until the next read, so a late sample never sees a stale zero
    if (HSEL && HREADY && HTRANS[1] && !HWRITE) begin
      nxt_st.rdata = 32'h0000_0000;
      case (HADDR[7:0])
        OTG_CONTROL_ADDR:     nxt_st.rdata[7:0] = st_ff.otg_ctl;
        POWER_CONTROL_ADDR:   nxt_st.rdata[7:0] = {st_ff.act_pend, 2'b00, st_ff.pwr_ctl[4],
                                                   busy, 1'b0, st_ff.pwr_ctl[1:0]};
        INTERRUPT_FLAG_ADDR:  nxt_st.rdata[7:0] = st_ff.flags;
        ERROR_FLAG_ADDR:      nxt_st.rdata[7:0] = st_ff.err_flags;
        ERROR_ENABLE_ADDR:    nxt_st.rdata[7:0] = st_ff.err_en;
        TRANSFER_STATUS_ADDR: nxt_st.rdata[7:0] = st_ff.tok_status;
        default:              nxt_st.rdata = 32'h0000_0000;
      endcase
    end
    // Register writes in the data phase
    if (st_ff.ph_valid && st_ff.ph_write) begin
      case (st_ff.ph_addr)
        OTG_CONTROL_ADDR:   nxt_st.otg_ctl = wr_data;
        POWER_CONTROL_ADDR: nxt_st.pwr_ctl = wr_data[4:0] & POWER_WRITE_MASK[4:0];
        ERROR_ENABLE_ADDR:  nxt_st.err_en = wr_data;
        ERROR_FLAG_ADDR:    nxt_st.err_flags = st_ff.err_flags & ~wr_data;
        default:            nxt_st.err_en = st_ff.err_en;
      endcase
    end
    // Error flags: set wins over clear
    nxt_st.err_flags = nxt_st.err_flags | (enabled ? ERROR_EVT : 8'h00);
    // Interrupt flags: a hardware set beats a write-one clear
    nxt_st.flags = (st_ff.flags & ~clr_mask) | hw_set;
    nxt_st.flags[ERROR_SUMMARY_BIT] = |(nxt_st.err_flags & st_ff.err_en);
    // Token status: one-deep queue behind the visible entry
    if (clr_mask[TOKEN_DONE_BIT] && st_ff.tok_full) begin
      nxt_st.tok_status = st_ff.tok_queued;
      nxt_st.tok_full = 1'b0;
      nxt_st.flags[TOKEN_DONE_BIT] = 1'b1;
    end
    if (hw_set[TOKEN_DONE_BIT]) begin
      if (!st_ff.flags[TOKEN_DONE_BIT] || clr_mask[TOKEN_DONE_BIT] && !st_ff.tok_full) begin
        nxt_st.tok_status = TOKEN_STATUS;
      end else begin
        nxt_st.tok_queued = TOKEN_STATUS;
        nxt_st.tok_full = 1'b1;
      end
    end
    // Line timers
    nxt_st.k_cnt = count_up(st_ff.k_cnt, k_state && enabled);
    nxt_st.quiet_cnt = count_up(st_ff.quiet_cnt, j_state && enabled);
    nxt_st.idle_cnt = count_up(st_ff.idle_cnt, j_state && enabled);
    // Activity pending: a one-cycle pulse on each new bus activity
    nxt_st.prev_active = bus_active;
    if (enabled && bus_active && !st_ff.prev_active) begin
      nxt_st.act_pend = 1'b1;
    end else if (st_ff.act_pend) begin
      nxt_st.act_pend = 1'b0;
    end
    // Busy sequencer: disable takes a settling time before re-enable
    nxt_st.busy_cnt = 8'h00;
    case (st_ff.pwr_state)
      UOTG_OFF:  if (enabled) begin
        nxt_st.pwr_state = UOTG_ON;
      end
      UOTG_ON:   if (!enabled) begin
        nxt_st.pwr_state = UOTG_STOP;
      end
      UOTG_STOP: begin
        nxt_st.busy_cnt = st_ff.busy_cnt + 8'h01;
        if (st_ff.busy_cnt == 8'(BUSY_CYCLES - 1)) begin
          nxt_st.pwr_state = UOTG_OFF;
        end
      end
      default:   nxt_st.pwr_state = UOTG_OFF;
    endcase
    // Pin controls, all released while disabled
    nxt_st.pulls = enabled ? {pull_sel, 4'h0} : 8'h00;
    nxt_st.vbus[2] = enabled && st_ff.otg_ctl[VBUS_POWER_BIT];
    nxt_st.vbus[1] = enabled && st_ff.otg_ctl[VBUS_CHARGE_BIT];
    nxt_st.vbus[0] = enabled && st_ff.otg_ctl[VBUS_DISCHARGE_BIT];
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      st_ff <= '{pwr_state: UOTG_OFF, otg_ctl: OTG_CONTROL_RST,
                 pwr_ctl: POWER_CONTROL_RST[4:0], flags: FLAGS_RST, default: '0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign HRDATA = st_ff.rdata;
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign DPLUS_PULLUP_EN = st_ff.pulls[7];
  assign DMINUS_PULLUP_EN = st_ff.pulls[6];
  assign DPLUS_PULLDOWN_EN = st_ff.pulls[5];
  assign DMINUS_PULLDOWN_EN = st_ff.pulls[4];
  assign VBUS_POWER_ON = st_ff.vbus[2];
  assign VBUS_CHARGE_EN = st_ff.vbus[1];
  assign VBUS_DISCHARGE_EN = st_ff.vbus[0];
  // Suspend stops the 48 MHz clock; disabled module also gets no clock
  assign USB_CLK_GATE_EN = st_ff.pwr_ctl[OPERATE_BIT] && !st_ff.pwr_ctl[SUSPEND_BIT];
  assign XCVR_LOW_POWER = !st_ff.pwr_ctl[OPERATE_BIT] || st_ff.pwr_ctl[SUSPEND_BIT];
  assign MODULE_ACTIVE = st_ff.pwr_ctl[OPERATE_BIT];
  assign SLEEP_BLOCK = SLEEP_REQ && st_ff.pwr_ctl[SLEEP_GUARD_BIT] &&
                       (st_ff.act_pend || bus_active && enabled || |st_ff.flags);
  assign ACTIVITY_PENDING = st_ff.act_pend;

  a_pull_follow: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    $past(enabled) && $past(st_ff.otg_ctl[SW_PULL_BIT])
      |-> DPLUS_PULLUP_EN == $past(st_ff.otg_ctl[DPLUS_PULLUP_BIT]))
    else $error("pull-up does not follow software bit");
  a_hw_pull: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    $past(enabled) && !$past(st_ff.otg_ctl[SW_PULL_BIT])
      |-> {DPLUS_PULLUP_EN, DMINUS_PULLUP_EN} == $past(HW_PULL_REQ[3:2]))
    else $error("hardware pull request not followed");
  a_vbus_power: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    VBUS_POWER_ON |-> $past(st_ff.otg_ctl[VBUS_POWER_BIT]))
    else $error("VBUS powered without control bit");
  a_off_quiet: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    !$past(enabled) |-> !VBUS_CHARGE_EN && !VBUS_DISCHARGE_EN && !DMINUS_PULLDOWN_EN)
    else $error("outputs active while disabled");
  a_flag_sticky: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    st_ff.flags[STALL_BIT] && !clr_mask[STALL_BIT] |=> st_ff.flags[STALL_BIT])
    else $error("stall flag lost without clear");
  a_set_wins: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    hw_set[FRAME_START_BIT] && clr_mask[FRAME_START_BIT] |=> st_ff.flags[FRAME_START_BIT])
    else $error("clear beat a same-cycle set");
  a_resume_time: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    $rose(st_ff.flags[RESUME_BIT]) |-> $past(st_ff.k_cnt) == CNT_W'(LINE_CYCLES - 1))
    else $error("resume flag set before 2.5 us of K");
  a_busy_hold: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    $fell(enabled) |=> busy [*8])
    else $error("busy dropped too soon after disable");
  a_err_mask: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    st_ff.flags[ERROR_SUMMARY_BIT] |-> |($past(nxt_st.err_flags) & $past(st_ff.err_en)))
    else $error("error summary set by masked error");
  a_token_adv: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    clr_mask[TOKEN_DONE_BIT] && st_ff.tok_full && !hw_set[TOKEN_DONE_BIT]
      |=> st_ff.tok_status == $past(st_ff.tok_queued) && !st_ff.tok_full)
    else $error("status queue did not advance");

endmodule

// *** dv/uotgpc_cable_model.sv ***
// Cable partner model: drives the bus line states seen at the data pins
`timescale 1ns/100ps
module uotgpc_cable_model (
  // Clock
  input  wire logic clk,
  // Bus lines
  output logic      line_dp,
  output logic      line_dm
);
  // Nothing attached drives the lines, so the far-end pull-downs leave them at SE0
  initial begin
    line_dp = 1'b0;
    line_dm = 1'b0;
  end

  // Holds one line state for n cycles, then lets the pull-downs take the lines
  task automatic hold(input logic dp, input logic dm, input int n);
    line_dp <= dp;
    line_dm <= dm;
    repeat (n) @(posedge clk);
    line_dp <= 1'b0;
    line_dm <= 1'b0;
    @(posedge clk);
  endtask
endmodule

// *** dv/tb.sv ***
// Register-level testbench of the USB power and interrupt block
`timescale 1ns/100ps
module tb;
  import uotgpc_pkg::*;
  logic        core_clk, reset_n, hsel, hwrite, host_mode, host_op_en, sleep_req;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [3:0]  hw_pull_req;
  logic [4:0]  evt;
  logic [7:0]  token_status, error_evt;
  logic        hreadyout, hresp, line_dp, line_dm;
  logic        clk_gate, xcvr_lp, mod_active, sleep_block, act_pend;
  wire  [7:0]  ctl_out;
  int          n_fail, compares, act_cnt;

  assign ctl_out[2] = 1'b0;

  uotgpc_top #(.IDLE_CYCLES(50)) DUT (
    .CORE_CLK(core_clk), .RESET_N(reset_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
    .HREADYOUT(hreadyout), .HRESP(hresp), .LINE_DP(line_dp), .LINE_DM(line_dm),
    .HW_PULL_REQ(hw_pull_req), .HOST_MODE(host_mode), .HOST_OPERATION_EN(host_op_en),
    .LOW_SPEED(1'b0), .STALL_EVT(evt[4]), .TOKEN_DONE_EVT(evt[3]),
    .TOKEN_STATUS(token_status), .FRAME_START_EVT(evt[2]), .BUS_RESET_EVT(evt[1]),
    .DETACH_EVT(evt[0]), .ERROR_EVT(error_evt), .SLEEP_REQ(sleep_req),
    .DPLUS_PULLUP_EN(ctl_out[7]), .DMINUS_PULLUP_EN(ctl_out[6]),
    .DPLUS_PULLDOWN_EN(ctl_out[5]), .DMINUS_PULLDOWN_EN(ctl_out[4]),
    .VBUS_POWER_ON(ctl_out[3]), .VBUS_CHARGE_EN(ctl_out[1]), .VBUS_DISCHARGE_EN(ctl_out[0]),
    .USB_CLK_GATE_EN(clk_gate), .XCVR_LOW_POWER(xcvr_lp), .MODULE_ACTIVE(mod_active),
    .SLEEP_BLOCK(sleep_block), .ACTIVITY_PENDING(act_pend)
  );

  uotgpc_cable_model u_cable (.clk(core_clk), .line_dp(line_dp), .line_dm(line_dm));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Activity pending is a short pulse, so it is counted rather than sampled
  always @(posedge core_clk) begin
    if (act_pend === 1'b1) act_cnt++;
  end

  task automatic conclude();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wait_rdy();
    int i;
    for (i = 0; i < 50; i++) begin
      @(posedge core_clk);
      if (hreadyout === 1'b1) break;
    end
    if (i == 50) begin
      n_fail++;
      conclude();
    end
  endtask

  // One single-word transfer; address held until ready, data taken at the closing edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    hsize  <= 3'h2;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask

  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] e);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0, r);
    chk(what, r & m, e);
  endtask

  task automatic pulse(input logic [4:0] m, input logic [7:0] e);
    evt       <= m;
    error_evt <= e;
    @(posedge core_clk);
    evt       <= 5'h00;
    error_evt <= 8'h00;
    @(posedge core_clk);
  endtask

  initial begin
    repeat (100000) @(posedge core_clk);
    n_fail++;
    conclude();
  end

  initial begin
    int          k;
    logic [31:0] r;
    reset_n = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
    hsize = 3'h2; hwdata = 32'h0; hw_pull_req = 4'h0; host_mode = 1'b0; host_op_en = 1'b0;
    sleep_req = 1'b0; evt = 5'h00; token_status = 8'h00; error_evt = 8'h00;
    n_fail = 0; compares = 0; act_cnt = 0;
    repeat (16) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    rchk("otg reset", OTG_CONTROL_ADDR, 32'hffffffff, 32'h0);
    rchk("pwr reset", POWER_CONTROL_ADDR, 32'hffffffff, 32'h0);
    rchk("flags reset", INTERRUPT_FLAG_ADDR, 32'hffffffff, 32'h0);
    rchk("unmapped", 8'h40, 32'hffffffff, 32'h0);
    wr(POWER_CONTROL_ADDR, 32'hffffff01);
    rchk("pwr on", POWER_CONTROL_ADDR, 32'hffffffff, 32'h09);
    chk("active", {31'h0, mod_active}, 32'h1);
    $display("test registers done");
    for (k = 0; k < 8; k++) begin
      if (k == SW_PULL_BIT) continue;
      wr(OTG_CONTROL_ADDR, 32'hffffff04 | (32'h1 << k));
      repeat (2) @(posedge core_clk);
      chk("ctl outputs", {24'h0, ctl_out}, 32'h1 << k);
      rchk("otg read", OTG_CONTROL_ADDR, 32'hffffffff, 32'h04 | (32'h1 << k));
    end
    hw_pull_req <= 4'h5;
    wr(OTG_CONTROL_ADDR, 32'hf0);
    repeat (2) @(posedge core_clk);
    chk("hw pulls", {24'h0, ctl_out}, 32'h50);
    $display("test otg control done");
    token_status <= 8'h11;
    pulse(5'b11110, 8'h00);
    rchk("flags set", INTERRUPT_FLAG_ADDR, 32'h8f, 32'h8d);
    wr(INTERRUPT_FLAG_ADDR, 32'h0);
    rchk("zero write", INTERRUPT_FLAG_ADDR, 32'h8f, 32'h8d);
    wr(INTERRUPT_FLAG_ADDR, 32'h84);
    rchk("w1c", INTERRUPT_FLAG_ADDR, 32'h8f, 32'h09);
    token_status <= 8'h22;
    pulse(5'b01000, 8'h00);
    rchk("status 1", TRANSFER_STATUS_ADDR, 32'hff, 32'h11);
    wr(INTERRUPT_FLAG_ADDR, 32'h08);
    rchk("token kept", INTERRUPT_FLAG_ADDR, 32'h08, 32'h08);
    rchk("status 2", TRANSFER_STATUS_ADDR, 32'hff, 32'h22);
    wr(INTERRUPT_FLAG_ADDR, 32'h09);
    rchk("token gone", INTERRUPT_FLAG_ADDR, 32'h09, 32'h0);
    host_mode <= 1'b1;
    pulse(5'b00001, 8'h00);
    rchk("detach", INTERRUPT_FLAG_ADDR, 32'h01, 32'h01);
    wr(INTERRUPT_FLAG_ADDR, 32'h01);
    pulse(5'b00000, 8'h04);
    rchk("masked err", INTERRUPT_FLAG_ADDR, 32'h02, 32'h0);
    wr(ERROR_FLAG_ADDR, 32'hff);
    wr(ERROR_ENABLE_ADDR, 32'h04);
    pulse(5'b00000, 8'h04);
    rchk("err summary", INTERRUPT_FLAG_ADDR, 32'h02, 32'h02);
    wr(INTERRUPT_FLAG_ADDR, 32'h02);
    rchk("summary ro", INTERRUPT_FLAG_ADDR, 32'h02, 32'h02);
    wr(ERROR_FLAG_ADDR, 32'h04);
    rchk("summary off", INTERRUPT_FLAG_ADDR, 32'h02, 32'h0);
    $display("test flags done");
    wr(INTERRUPT_FLAG_ADDR, 32'hfd);
    sleep_req <= 1'b1;
    u_cable.hold(1'b0, 1'b1, 100);
    rchk("short k", INTERRUPT_FLAG_ADDR, 32'h20, 32'h0);
    chk("no guard", {31'h0, sleep_block}, 32'h0);
    // Count from before J, so the J to SE0 step is surely seen as new activity
    k = act_cnt;
    u_cable.hold(1'b1, 1'b0, 60);
    rchk("idle", INTERRUPT_FLAG_ADDR, 32'h70, 32'h10);
    // The resume enable lives outside this block and stays off here
    u_cable.hold(1'b0, 1'b1, 300);
    chk("activity", {31'h0, act_cnt > k}, 32'h1);
    rchk("resume", INTERRUPT_FLAG_ADDR, 32'h20, 32'h20);
    wr(POWER_CONTROL_ADDR, 32'h11);
    @(posedge core_clk);
    chk("guard", {31'h0, sleep_block}, 32'h1);
    host_op_en <= 1'b1;
    u_cable.hold(1'b1, 1'b0, 300);
    rchk("attach", INTERRUPT_FLAG_ADDR, 32'h40, 32'h40);
    $display("test line states done");
    wr(POWER_CONTROL_ADDR, 32'h03);
    repeat (2) @(posedge core_clk);
    chk("low power", {31'h0, xcvr_lp}, 32'h1);
    chk("gate off", {31'h0, clk_gate}, 32'h0);
    wr(POWER_CONTROL_ADDR, 32'h01);
    repeat (2) @(posedge core_clk);
    chk("normal", {31'h0, xcvr_lp}, 32'h0);
    chk("gate", {31'h0, clk_gate}, 32'h1);
    wr(POWER_CONTROL_ADDR, 32'h00);
    rchk("busy after off", POWER_CONTROL_ADDR, 32'h09, 32'h08);
    chk("inactive", {31'h0, mod_active}, 32'h0);
    pulse(5'b10000, 8'h00);
    // No write may land while the module winds down
    for (k = 0; k < 30; k++) begin
      xfer(1'b0, POWER_CONTROL_ADDR, 32'h0, r);
      if (r[MODULE_BUSY_BIT] === 1'b0) break;
    end
    chk("busy clears", {31'h0, r[MODULE_BUSY_BIT]}, 32'h0);
    wr(POWER_CONTROL_ADDR, 32'h01);
    rchk("event ignored", INTERRUPT_FLAG_ADDR, 32'h80, 32'h0);
    $display("test power done");
    conclude();
  end
endmodule
